// [core/masc_curve.sv]
// ten milliampere scaling curves sharing one sequencer and serial divider
// assumes channel values and presence flags come from logic on mclk
`timescale 1ns/1ps

// Contract
// - per-curve enable gates curve and measurement
// - input taken from selected channel
// - filter time constant in 5 ms steps
// - ten curves, each with own limit flag
// - limit flag only when range check enabled
// - input below minimum raises limit flag
// - input above maximum raises limit flag
// - received input value readable per curve
// - scaled output value readable per curve
// - first-order low-pass when filtering enabled
// - limit flag is a plain registered output
// - lost input holds last valid value
// - refresh once per update cycle, 5 ms steps
// - output float, floor, ceiling or nearest
// - first point input and output settable
// - second point completes default line
// - optional user curve up to twenty points
module masc_curve #(
  parameter int unsigned TICK_CYCLES = masc_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // settings
  input masc_pkg::masc_cfg_t cfg [masc_pkg::NINST],
  input masc_pkg::masc_pt_t pts [masc_pkg::NINST][masc_pkg::NPTS],
  // measurement channels
  input wire logic signed [masc_pkg::VW-1:0] ch_val [masc_pkg::NCH],
  input wire logic [masc_pkg::NCH-1:0] ch_ok,
  // results
  output logic signed [masc_pkg::VW-1:0] in_val [masc_pkg::NINST],
  output logic signed [masc_pkg::VW-1:0] out_val [masc_pkg::NINST],
  output logic [masc_pkg::NINST-1:0] curve_input_limit_violation
);
  import masc_pkg::*;

  // 5 ms step divider
  logic [TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick_reg, tick_next;

  always_comb begin
    tick_next = 1'b0;
    tick_cnt_next = tick_cnt_reg + 1'b1;
    if (tick_cnt_reg == TICK_W'(TICK_CYCLES - 1)) begin
      tick_cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // per-curve update cycle timers
  logic [UPD_W-1:0] ucnt_reg [NINST];
  logic [UPD_W-1:0] ucnt_next [NINST];
  logic [NINST-1:0] pend_reg, pend_next, fire, svc_clr;

  for (genvar i = 0; i < NINST; i++) begin : g_inst
    always_comb begin
      fire[i] = 1'b0;
      ucnt_next[i] = ucnt_reg[i];
      if (!cfg[i].enable) begin
        ucnt_next[i] = '0;
      end else if (tick_reg) begin
        if (ucnt_reg[i] + 1'b1 >= cfg[i].upd) begin
          ucnt_next[i] = '0;
          fire[i] = 1'b1;
        end else begin
          ucnt_next[i] = ucnt_reg[i] + 1'b1;
        end
      end
      // a new fire beats a same-cycle service clear
      pend_next[i] = cfg[i].enable & ((pend_reg[i] & ~svc_clr[i]) | fire[i]);
    end

    always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
        ucnt_reg[i] <= '0;
        pend_reg[i] <= 1'b0;
      end else begin
        ucnt_reg[i] <= ucnt_next[i];
        pend_reg[i] <= pend_next[i];
      end
    end
  end

  // sequencer and shared divider
  masc_state_t st_reg, st_next;
  logic [3:0] idx_reg, idx_next;
  logic signed [VW-1:0] x_reg, x_next, v_reg, v_next, yi_reg, yi_next;
  logic signed [VW-1:0] inv_reg [NINST];
  logic signed [VW-1:0] inv_next [NINST];
  logic signed [VW-1:0] outv_reg [NINST];
  logic signed [VW-1:0] outv_next [NINST];
  logic [NINST-1:0] oor_reg, oor_next;
  logic [PW-1:0] dq_reg, dq_next;
  logic [VW-1:0] dd_reg, dd_next, dr_reg, dr_next;
  logic [6:0] dc_reg, dc_next;
  logic dn_reg, dn_next;

  always_comb begin
    masc_cfg_t c;
    logic [VW:0] rsh;
    logic signed [PW-1:0] ld_num, qs, rq;
    logic signed [VW-1:0] ld_den, xi, xj, yj, o;
    logic ld;
    logic [4:0] n, seg;
    c = cfg[idx_reg];
    rsh = '0;
    ld = 1'b0;
    ld_num = '0;
    ld_den = '0;
    st_next = st_reg;
    idx_next = idx_reg;
    x_next = x_reg;
    v_next = v_reg;
    yi_next = yi_reg;
    inv_next = inv_reg;
    outv_next = outv_reg;
    oor_next = oor_reg;
    svc_clr = '0;
    dq_next = dq_reg;
    dd_next = dd_reg;
    dr_next = dr_reg;
    dc_next = dc_reg;
    dn_next = dn_reg;
    qs = dn_reg ? -PW'(signed'(dq_reg)) : PW'(signed'(dq_reg));
    // segment holding the present value
    n = (c.multi_en && c.npts > 5'd2) ?
        ((c.npts > 5'(NPTS)) ? 5'(NPTS) : c.npts) : 5'd2;
    seg = '0;
    for (int k = 1; k < NPTS - 1; k++) begin
      if (5'(k) < n - 1'b1 && v_reg >= pts[idx_reg][k].x) begin
        seg = 5'(k);
      end
    end
    xi = pts[idx_reg][seg].x;
    xj = pts[idx_reg][seg + 1'b1].x;
    yj = pts[idx_reg][seg + 1'b1].y;
    o = yi_reg + VW'(qs);
    rq = qs;
    // restoring divider on magnitudes, one quotient bit a cycle
    if (dc_reg != 7'h00) begin
      rsh = {dr_reg, dq_reg[PW-1]};
      dq_next = {dq_reg[PW-2:0], 1'b0};
      dr_next = rsh[VW-1:0];
      if (rsh >= {1'b0, dd_reg}) begin
        dr_next = VW'(rsh - {1'b0, dd_reg});
        dq_next[0] = 1'b1;
      end
      dc_next = dc_reg - 1'b1;
    end
    unique case (st_reg)
      MASC_IDLE: begin
        for (int i = NINST - 1; i >= 0; i--) begin
          if (pend_reg[i]) begin
            idx_next = 4'(i);
          end
        end
        if (pend_reg != '0) begin
          svc_clr[idx_next] = 1'b1;
          c = cfg[idx_next];
          // lost channel keeps the stored value
          x_next = ch_ok[c.sel] ? ch_val[c.sel] : inv_reg[idx_next];
          if (c.filt_en && c.tau > TAU_W'(c.upd)) begin
            // y += (x - y) * upd / tau
            ld = 1'b1;
            ld_num = (PW'(x_next) - PW'(inv_reg[idx_next])) *
                     PW'(signed'({1'b0, c.upd}));
            ld_den = VW'(signed'({1'b0, c.tau}));
            st_next = MASC_FILT;
          end else begin
            v_next = x_next;
            st_next = MASC_SEG;
          end
        end
      end
      MASC_FILT: begin
        if (dc_reg == 7'h00) begin
          v_next = inv_reg[idx_reg] + VW'(qs);
          st_next = MASC_SEG;
        end
      end
      MASC_SEG: begin
        inv_next[idx_reg] = v_reg;
        oor_next[idx_reg] = c.range_en &&
          (v_reg < c.in_min || v_reg > c.in_max);
        yi_next = pts[idx_reg][seg].y;
        // equal x: zero slope, yet still rounded
        ld = 1'b1;
        ld_den = VAL_ONE;
        st_next = MASC_INTP;
        if (xj != xi) begin
          ld_num = (PW'(v_reg) - PW'(xi)) *
                   (PW'(yj) - PW'(pts[idx_reg][seg].y));
          ld_den = xj - xi;
        end
      end
      MASC_INTP: begin
        if (dc_reg == 7'h00) begin
          if (c.rnd == MASC_RND_FLOAT) begin
            outv_next[idx_reg] = o;
            st_next = MASC_IDLE;
          end else begin
            ld = 1'b1;
            ld_num = PW'(o);
            ld_den = VAL_ONE;
            st_next = MASC_RND;
          end
        end
      end
      MASC_RND: begin
        if (dc_reg == 7'h00) begin
          unique case (c.rnd)
            MASC_RND_FLOOR: begin
              if (dn_reg && dr_reg != '0) rq = qs - 1'b1;
            end
            MASC_RND_CEIL: begin
              if (!dn_reg && dr_reg != '0) rq = qs + 1'b1;
            end
            MASC_RND_NEAR: begin
              if ({dr_reg, 1'b0} >= {1'b0, dd_reg}) begin
                rq = dn_reg ? qs - 1'b1 : qs + 1'b1;
              end
            end
            MASC_RND_FLOAT: rq = qs;
          endcase
          outv_next[idx_reg] = VW'(rq * PW'(VAL_ONE));
          st_next = MASC_IDLE;
        end
      end
      default: st_next = MASC_IDLE;
    endcase
    if (ld) begin
      dn_next = ld_num[PW-1] ^ ld_den[VW-1];
      dq_next = ld_num[PW-1] ? PW'(-ld_num) : PW'(ld_num);
      dd_next = ld_den[VW-1] ? VW'(-ld_den) : VW'(ld_den);
      dr_next = '0;
      dc_next = DIV_STEPS;
    end
    for (int i = 0; i < NINST; i++) begin
      if (!cfg[i].enable) oor_next[i] = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= MASC_IDLE;
      idx_reg <= '0;
      x_reg <= '0;
      v_reg <= '0;
      yi_reg <= '0;
      oor_reg <= '0;
      dq_reg <= '0;
      dd_reg <= '0;
      dr_reg <= '0;
      dc_reg <= '0;
      dn_reg <= 1'b0;
      for (int i = 0; i < NINST; i++) begin
        inv_reg[i] <= '0;
        outv_reg[i] <= '0;
      end
    end else begin
      st_reg <= st_next;
      idx_reg <= idx_next;
      x_reg <= x_next;
      v_reg <= v_next;
      yi_reg <= yi_next;
      oor_reg <= oor_next;
      dq_reg <= dq_next;
      dd_reg <= dd_next;
      dr_reg <= dr_next;
      dc_reg <= dc_next;
      dn_reg <= dn_next;
      inv_reg <= inv_next;
      outv_reg <= outv_next;
    end
  end

  assign in_val = inv_reg;
  assign out_val = outv_reg;
  assign curve_input_limit_violation = oor_reg;
endmodule

// [core/masc_pkg.sv]
// constants, settings layout and types for the milliampere scaling curves
// values are signed fixed point with 1 lsb = 0.00001; times count 5 ms steps
package masc_pkg;
  localparam int NINST = 10;
  localparam int NCH = 4;
  localparam int NPTS = 20;
  localparam int VW = 48;
  localparam int PW = 100;
  localparam int CLK_NS = 20;
  localparam int STEP_NS = 5_000_000;
  localparam int TICK_CYC = STEP_NS / CLK_NS;
  localparam int TICK_W = 18;
  localparam int UPD_W = 11;
  localparam int TAU_W = 20;
  localparam int STEP_MS = 5;
  localparam int TAU_DEF_MS = 1000;
  localparam int UPD_DEF_MS = 150;
  localparam logic [TAU_W-1:0] TAU_DEF = TAU_W'(TAU_DEF_MS / STEP_MS);
  localparam logic [UPD_W-1:0] UPD_DEF = UPD_W'(UPD_DEF_MS / STEP_MS);
  // one whole unit of a value
  localparam logic signed [VW-1:0] VAL_ONE = 48'h0000_0001_86A0;
  localparam logic signed [VW-1:0] VAL_ZERO = 48'h0000_0000_0000;
  localparam logic [6:0] DIV_STEPS = 7'(PW);

  typedef enum logic [1:0] {
    MASC_RND_FLOAT = 2'b00,
    MASC_RND_FLOOR = 2'b01,
    MASC_RND_CEIL = 2'b10,
    MASC_RND_NEAR = 2'b11
  } masc_rnd_t;

  typedef enum logic [2:0] {
    MASC_IDLE = 3'b000,
    MASC_FILT = 3'b001,
    MASC_SEG = 3'b010,
    MASC_INTP = 3'b011,
    MASC_RND = 3'b100
  } masc_state_t;

  typedef struct packed {
    logic enable;
    logic [1:0] sel;
    logic filt_en;
    logic [TAU_W-1:0] tau;
    logic range_en;
    logic signed [VW-1:0] in_min;
    logic signed [VW-1:0] in_max;
    logic [UPD_W-1:0] upd;
    masc_rnd_t rnd;
    logic multi_en;
    logic [4:0] npts;
  } masc_cfg_t;

  typedef struct packed {
    logic signed [VW-1:0] x;
    logic signed [VW-1:0] y;
  } masc_pt_t;

  localparam masc_cfg_t CFG_DEF = '{enable: 1'b0, sel: 2'h0,
    filt_en: 1'b0, tau: TAU_DEF, range_en: 1'b0, in_min: VAL_ZERO,
    in_max: VAL_ZERO, upd: UPD_DEF, rnd: MASC_RND_FLOAT,
    multi_en: 1'b0, npts: 5'h02};
endpackage

// [verif/masc_chan_model.sv]
// channel model: steady values, or lost channels with wandering data
// assumes the bench sets want and live on mclk
`timescale 1ns/1ps
module masc_chan_model (
  // clock
  input wire logic mclk,
  // commands
  input wire logic signed [masc_pkg::VW-1:0] want [masc_pkg::NCH],
  input wire logic [masc_pkg::NCH-1:0] live,
  // channels
  output logic signed [masc_pkg::VW-1:0] ch_val [masc_pkg::NCH],
  output logic [masc_pkg::NCH-1:0] ch_ok
);
  import masc_pkg::*;
  always_ff @(posedge mclk) begin
    ch_ok <= live;
    for (int i = 0; i < NCH; i++)
      ch_val[i] <= live[i] ? want[i] : ~ch_val[i];
  end
endmodule

// [verif/masc_curve_tb.sv]
// bench for the scaling curves, curve 0 exercised, curve 1 at the end
// assumes 10 clocks per 5 ms step and the default 30-step update
`timescale 1ns/1ps
module masc_curve_tb;
  import masc_pkg::*;
  typedef logic signed [VW-1:0] masc_v_t;
  typedef struct {
    logic [1:0] sel;
    masc_rnd_t rnd;
    masc_v_t vin;
    masc_v_t vout;
  } masc_row_t;
  masc_row_t rows [4] = '{
    '{2'h0, MASC_RND_FLOAT, 48'h0000_0000_C350, 48'h0000_0001_86A0},
    '{2'h1, MASC_RND_FLOOR, 48'h0000_0001_E240, 48'h0000_0003_0D40},
    '{2'h2, MASC_RND_CEIL, 48'h0000_0001_E240, 48'h0000_0004_93E0},
    '{2'h3, MASC_RND_NEAR, 48'h0000_0002_191C, 48'h0000_0004_93E0}};
  logic mclk, rst;
  masc_cfg_t cfg [NINST];
  masc_pt_t pts [NINST][NPTS];
  masc_v_t want [NCH], ch_val [NCH], in_val [NINST], out_val [NINST];
  logic [NCH-1:0] live, ch_ok;
  logic [NINST-1:0] flg;
  int n_fail = 0, cmp_count = 0;
  masc_chan_model u_chan (.mclk(mclk), .want(want), .live(live),
    .ch_val(ch_val), .ch_ok(ch_ok));
  masc_curve #(.TICK_CYCLES(10)) uut (.mclk(mclk), .rst(rst), .cfg(cfg),
    .pts(pts), .ch_val(ch_val), .ch_ok(ch_ok), .in_val(in_val),
    .out_val(out_val), .curve_input_limit_violation(flg));
  task automatic chk(input masc_v_t g, input masc_v_t e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic feed(input masc_v_t v);
    @(posedge mclk);
    want[0] <= v;
    repeat (850) @(posedge mclk);
    #1;
  endtask
  task automatic wait_chg;
    masc_v_t old;
    old = in_val[0];
    for (int i = 0; i < 1000 && in_val[0] === old; i++) begin
      @(posedge mclk);
      #1;
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    n_fail++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    live = '1;
    want = '{48'h0000_0000_C350, 48'h0000_0001_E240, 48'h0000_0001_E240,
      48'h0000_0002_191C};
    foreach (cfg[i]) cfg[i] = CFG_DEF;
    foreach (pts[i, j]) pts[i][j] = '{j * VAL_ONE, 2 * j * VAL_ONE};
    cfg[0].enable = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk(in_val[0], '0);
    foreach (rows[r]) begin
      @(posedge mclk);
      cfg[0].sel <= rows[r].sel;
      cfg[0].rnd <= rows[r].rnd;
      feed(want[0]);
      chk(in_val[0], rows[r].vin);
      chk(out_val[0], rows[r].vout);
      chk(VW'(flg[0]), '0);
    end
    @(posedge mclk);
    cfg[0].sel <= 2'h0;
    cfg[0].rnd <= MASC_RND_FLOAT;
    cfg[0].range_en <= 1'b1;
    cfg[0].in_max <= VAL_ONE;
    feed(48'h0000_0003_0D40);
    chk(VW'(flg[0]), VW'(1));
    feed(-VAL_ONE);
    chk(VW'(flg[0]), VW'(1));
    feed(48'h0000_0000_C350);
    chk(VW'(flg[0]), '0);
    chk(out_val[0], 48'h0000_0001_86A0);
    @(posedge mclk);
    cfg[0].multi_en <= 1'b1;
    cfg[0].npts <= 5'h03;
    pts[0][2].y <= 2 * VAL_ONE;
    feed(48'h0000_0002_49F0);
    chk(out_val[0], 48'h0000_0003_0D40);
    @(posedge mclk);
    cfg[0].multi_en <= 1'b0;
    pts[0][0].y <= -VAL_ONE;
    feed(48'h0000_0000_C350);
    chk(out_val[0], 48'h0000_0000_C350);
    @(posedge mclk);
    cfg[0].filt_en <= 1'b1;
    cfg[0].tau <= 20'h0_003C;
    want[0] <= 48'h0000_0002_49F0;
    wait_chg();
    chk(in_val[0], 48'h0000_0001_86A0);
    wait_chg();
    chk(in_val[0], 48'h0000_0001_E848);
    @(posedge mclk);
    cfg[0].filt_en <= 1'b0;
    feed(48'h0000_0000_C350);
    @(posedge mclk);
    live[0] <= 1'b0;
    feed(48'h0000_000D_BBA0);
    chk(in_val[0], 48'h0000_0000_C350);
    @(posedge mclk);
    live[0] <= 1'b1;
    feed(want[0]);
    chk(VW'(flg[0]), VW'(1));
    chk(in_val[0], 48'h0000_000D_BBA0);
    @(posedge mclk);
    cfg[0].enable <= 1'b0;
    cfg[1].enable <= 1'b1;
    cfg[1].range_en <= 1'b1;
    feed(48'h0000_0000_C350);
    chk(VW'(flg[0]), '0);
    chk(in_val[0], 48'h0000_000D_BBA0);
    chk(VW'(flg[1]), VW'(1));
    chk(in_val[1], 48'h0000_0000_C350);
    test_done();
  end
endmodule

// [verif/masc_monitor.sv]
// checker on curves 0 and 1 of the scaling curve block
// assumes slow channel values on curve 0
`timescale 1ns/1ps
module masc_monitor #(
  parameter int unsigned TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // settings and measurement channels
  input masc_pkg::masc_cfg_t cfg [masc_pkg::NINST],
  input masc_pkg::masc_pt_t pts [masc_pkg::NINST][masc_pkg::NPTS],
  input wire logic signed [masc_pkg::VW-1:0] ch_val [masc_pkg::NCH],
  input wire logic [masc_pkg::NCH-1:0] ch_ok,
  // results
  input wire logic signed [masc_pkg::VW-1:0] in_val [masc_pkg::NINST],
  input wire logic signed [masc_pkg::VW-1:0] out_val [masc_pkg::NINST],
  input wire logic [masc_pkg::NINST-1:0] curve_input_limit_violation
);
  import masc_pkg::*;
  wire [NINST-1:0] flg = curve_input_limit_violation;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_lost;
    (!ch_ok[0] && cfg[0].sel == 2'h0 && !cfg[0].filt_en) [*4];
  endsequence
  property p_hold;
    s_lost |-> $stable(in_val[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("lost moved");
  property p_dis;
    !cfg[0].enable |=> !flg[0];
  endproperty
  a_dis: assert property (p_dis) else $error("flag when off");
  property p_own;
    !cfg[1].enable [*2] |-> !flg[1];
  endproperty
  a_own: assert property (p_own) else $error("curve 1 flag");
  property p_rng;
    $rose(flg[0]) |-> $past(cfg[0].range_en);
  endproperty
  a_rng: assert property (p_rng) else $error("flag unarmed");
  property p_lim;
    $rose(flg[0]) |-> in_val[0] < $past(cfg[0].in_min) ||
      in_val[0] > $past(cfg[0].in_max);
  endproperty
  a_lim: assert property (p_lim) else $error("flag inside");
  property p_clr;
    $fell(flg[0]) && $past(cfg[0].enable) && $past(cfg[0].range_en) |->
      in_val[0] >= $past(cfg[0].in_min) &&
      in_val[0] <= $past(cfg[0].in_max);
  endproperty
  a_clr: assert property (p_clr) else $error("cleared outside");
  property p_upd;
    $changed(in_val[0]) |=> $stable(in_val[0]) [*8];
  endproperty
  a_upd: assert property (p_upd) else $error("update too soon");
  property p_sel;
    $changed(in_val[0]) && !cfg[0].filt_en && !$past(cfg[0].filt_en, 120)
      |-> in_val[0] == $past(ch_val[cfg[0].sel], 2);
  endproperty
  a_sel: assert property (p_sel) else $error("wrong channel");
  property p_rnd;
    $changed(out_val[0]) && cfg[0].rnd != MASC_RND_FLOAT &&
      $past(cfg[0].rnd, 250) == cfg[0].rnd |-> out_val[0] % VAL_ONE == 0;
  endproperty
  a_rnd: assert property (p_rnd) else $error("not whole");
endmodule

bind masc_curve masc_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
  .mclk(mclk), .rst(rst), .cfg(cfg), .pts(pts), .ch_val(ch_val),
  .ch_ok(ch_ok), .in_val(in_val), .out_val(out_val),
  .curve_input_limit_violation(curve_input_limit_violation));
